// File: pkg/pwm_out_regs.svh
// register map and field positions of the pwm output stage
`ifndef PWM_OUT_REGS_SVH
`define PWM_OUT_REGS_SVH
// ****************
// offsets
// ****************
`define OFS_CTRL 8'h00
`define OFS_SHDN 8'h04
`define OFS_OUTCFG 8'h08
`define OFS_RISE 8'h0C
`define OFS_FALL 8'h10
`define OFS_STATUS 8'h14
// ****************
// control register fields
// ****************
`define CTRL_RUN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 4
`define CTRL_STEERSYNC 5
`define CTRL_LOAD 6
`define CTRL_SYNCRISE 7
// ****************
// shutdown register fields
// ****************
`define SHDN_SRC_LO 0
`define SHDN_EN 8
`define SHDN_AUTO 9
`define SHDN_EVENT 10
`define SHDN_OVR 11
`define SHDN_ACTIVE 12
`define SHDN_RAW_LO 16
// ****************
// output configuration fields
// ****************
`define OCFG_EN_LO 0
`define OCFG_STEER_LO 8
`define OCFG_POL_LO 16
`define OCFG_LVL_LO 24
// ****************
// reset values and bus answers
// ****************
`define RST_CTRL 32'h0000_0000
`define RST_STEER 6'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: pkg/pwm_out_pkg.sv
// types of the pwm output stage
package pwm_out_pkg;
    typedef enum logic [3:0] {
        single_pwm_mode,
        single_pwm_complementary_mode,
        push_pull_mode,
        push_pull_complementary_mode,
        full_bridge_push_pull_mode,
        full_bridge_push_pull_compl_mode,
        pulse_skip_mode,
        pulse_skip_complementary_mode,
        bridge_reverse_mode,
        bridge_forward_mode,
        fixed_duty_mode,
        fixed_duty_complementary_mode,
        three_phase_mode
    } pwm_mode_t;
endpackage : pwm_out_pkg

// File: rtl/pwm_output_shutdown_sync.sv
// pwm output routing, auto-shutdown, sync output and timing buffers
`timescale 1ns/1ps
`include "pwm_out_regs.svh"

// Functional notes
// - pin from port latch or channel
// - single modes steer to any of six
// - disconnected steering forces pin low
// - other modes keep all steering connected
// - synced steering applies at next period while running
// - unsynced steering applies at once
// - active rise to fall, polarity selectable
// - shutdown drives per-channel level
// - shutdown level bypasses polarity
// - selected high source forces shutdown
// - shutdown is OR of eight sources
// - software shutdown event bit exists
// - override holds shutdown against restarts
// - auto restart when sources low
// - manual clear ignored while source high
// - output resumes at next period event
// - sync from period or rising event
// - slaves period at least master's
// - rising sync puts rise at period
// - timing buffered until load, then together
module pwm_output_shutdown_sync #(
    parameter int CHANS = 6,
    parameter int NSRC = 8,
    parameter int TW = 16,
    parameter bit SYNC_SELECTABLE = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic periodEvt,
    input wire logic riseEvt,
    input wire logic fallEvt,
    input wire logic [CHANS-1:0] modeChan,
    input wire logic [CHANS-1:0] portLatch,
    input wire logic [NSRC-1:0] shdnSrc,
    output logic [CHANS-1:0] pinOut,
    output logic [TW-1:0] riseTime,
    output logic [TW-1:0] fallTime,
    output logic syncOut
);
    if (CHANS != 6 || NSRC < 1 || NSRC > 8 || TW < 1 || TW > 16)
    begin : badParams
        $error("pwm_output_shutdown_sync: unsupported parameters");
    end

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return a == `OFS_CTRL || a == `OFS_SHDN || a == `OFS_OUTCFG ||
               a == `OFS_RISE || a == `OFS_FALL || a == `OFS_STATUS;
    endfunction : mapped

    // ****************
    // register state
    // ****************
    logic run_r, steerSync_r, loadReq_r, syncRise_r, active_r;
    pwm_out_pkg::pwm_mode_t mode_r;
    logic shdnEn_r, autoRestart_r, eventBit_r, override_r, shdnHold_r;
    logic [NSRC-1:0] srcSel_r;
    logic [CHANS-1:0] outEn_r, steer_r, pol_r, level_r, steerAct_r;
    logic [CHANS-1:0] pinReg_r, steerEff;
    logic [TW-1:0] riseBuf_r, fallBuf_r, riseDly_r, syncCnt_r;
    logic syncPend_r, singleMode, srcHit, shdnCond, shdnNow;

    // ****************
    // bus slave
    // ****************
    logic [7:0] awAddr_r;
    logic awHave_r, wHave_r, doWrite;
    logic [3:0] wStrb_r;
    logic [31:0] wData_r, wrCtrl, wrShdn, wrOcfg;
    logic [31:0] ctrlView, shdnView, ocfgView, statView;

    assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !wHave_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped({awAddr_r[7:2], 2'h0}) ?
                               `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        ctrlView = 32'h0000_0000;
        ctrlView[`CTRL_RUN] = run_r;
        ctrlView[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_r;
        ctrlView[`CTRL_STEERSYNC] = steerSync_r;
        ctrlView[`CTRL_LOAD] = loadReq_r;
        ctrlView[`CTRL_SYNCRISE] = syncRise_r;
        shdnView = 32'h0000_0000;
        shdnView[`SHDN_SRC_LO +: NSRC] = srcSel_r;
        shdnView[`SHDN_EN] = shdnEn_r;
        shdnView[`SHDN_AUTO] = autoRestart_r;
        shdnView[`SHDN_EVENT] = eventBit_r;
        shdnView[`SHDN_OVR] = override_r;
        shdnView[`SHDN_ACTIVE] = shdnNow;
        shdnView[`SHDN_RAW_LO +: NSRC] = shdnSrc;
        ocfgView = 32'h0000_0000;
        ocfgView[`OCFG_EN_LO +: CHANS] = outEn_r;
        ocfgView[`OCFG_STEER_LO +: CHANS] = steer_r;
        ocfgView[`OCFG_POL_LO +: CHANS] = pol_r;
        ocfgView[`OCFG_LVL_LO +: CHANS] = level_r;
        statView = 32'h0000_0000;
        statView[`OCFG_EN_LO +: CHANS] = pinOut;
        statView[`OCFG_STEER_LO +: CHANS] = steerEff;
        statView[`OCFG_POL_LO] = active_r;
        statView[`OCFG_LVL_LO] = shdnHold_r;
        wrCtrl = merge(ctrlView, wData_r, wStrb_r);
        wrShdn = merge(shdnView, wData_r, wStrb_r);
        wrOcfg = merge(ocfgView, wData_r, wStrb_r);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'h0}) ?
                           `RESP_OKAY : `RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'h0})
                `OFS_CTRL: s_axi_rdata <= ctrlView;
                `OFS_SHDN: s_axi_rdata <= shdnView;
                `OFS_OUTCFG: s_axi_rdata <= ocfgView;
                `OFS_RISE: s_axi_rdata <= 32'(riseBuf_r);
                `OFS_FALL: s_axi_rdata <= 32'(fallBuf_r);
                `OFS_STATUS: s_axi_rdata <= statView;
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    logic wrCtrlSel;
    logic wrShdnSel;
    assign wrCtrlSel = doWrite && {awAddr_r[7:2], 2'h0} == `OFS_CTRL;
    assign wrShdnSel = doWrite && {awAddr_r[7:2], 2'h0} == `OFS_SHDN;

    // ****************
    // control and configuration
    // ****************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            run_r <= 1'b0;
            mode_r <= pwm_out_pkg::single_pwm_mode;
            steerSync_r <= 1'b0;
            syncRise_r <= 1'b0;
            outEn_r <= '0;
            steer_r <= `RST_STEER;
            pol_r <= '0;
            level_r <= '0;
            riseBuf_r <= '0;
            fallBuf_r <= '0;
        end
        else if (doWrite)
        begin
            case ({awAddr_r[7:2], 2'h0})
                `OFS_CTRL:
                begin
                    run_r <= wrCtrl[`CTRL_RUN];
                    mode_r <= pwm_out_pkg::pwm_mode_t'(
                        wrCtrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
                    steerSync_r <= wrCtrl[`CTRL_STEERSYNC];
                    // reduced variant keeps sync on the period event
                    syncRise_r <= SYNC_SELECTABLE &&
                                  wrCtrl[`CTRL_SYNCRISE];
                end
                `OFS_OUTCFG:
                begin
                    outEn_r <= wrOcfg[`OCFG_EN_LO +: CHANS];
                    steer_r <= wrOcfg[`OCFG_STEER_LO +: CHANS];
                    pol_r <= wrOcfg[`OCFG_POL_LO +: CHANS];
                    level_r <= wrOcfg[`OCFG_LVL_LO +: CHANS];
                end
                `OFS_RISE: riseBuf_r <= TW'(merge(32'(riseBuf_r), wData_r,
                                              wStrb_r));
                `OFS_FALL: fallBuf_r <= TW'(merge(32'(fallBuf_r), wData_r,
                                              wStrb_r));
                default: ;
            endcase
        end
    end

    // ****************
    // timing buffer transfer
    // ****************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            loadReq_r <= 1'b0;
            riseTime <= '0;
            fallTime <= '0;
            riseDly_r <= '0;
        end
        else
        begin
            if (periodEvt && loadReq_r)
            begin
                // both values move in the same period, never one alone
                riseTime <= syncRise_r ? '0 : riseBuf_r;
                fallTime <= fallBuf_r;
                riseDly_r <= riseBuf_r;
                loadReq_r <= 1'b0;
            end
            // a new request written at the boundary is not lost
            if (wrCtrlSel && wrCtrl[`CTRL_LOAD])
                loadReq_r <= 1'b1;
        end
    end

    // ****************
    // steering
    // ****************
    assign singleMode = mode_r == pwm_out_pkg::single_pwm_mode ||
        mode_r == pwm_out_pkg::single_pwm_complementary_mode;
    assign steerEff = singleMode ? steerAct_r : '1;

    always_ff @(posedge clk)
    begin
        if (rst)
            steerAct_r <= `RST_STEER;
        else if (!steerSync_r || !run_r)
            steerAct_r <= steer_r;
        else if (periodEvt)
            steerAct_r <= steer_r;
    end

    // ****************
    // active interval and channel levels
    // ****************
    always_ff @(posedge clk)
    begin
        if (rst || !run_r)
            active_r <= 1'b0;
        else if (fallEvt)
            active_r <= 1'b0;
        else if (riseEvt)
            active_r <= 1'b1;
    end

    logic [CHANS-1:0] chanAct;
    always_comb
    begin
        case (mode_r)
            pwm_out_pkg::single_pwm_mode: chanAct = {CHANS{active_r}};
            pwm_out_pkg::single_pwm_complementary_mode:
                chanAct = {CHANS/2{!active_r, active_r}};
            default: chanAct = modeChan;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            pinReg_r <= '0;
        else
        begin
            for (int i = 0; i < CHANS; i++)
            begin
                if (!steerEff[i])
                    pinReg_r[i] <= 1'b0;
                else if (outEn_r[i])
                    pinReg_r[i] <= (chanAct[i] && run_r) ^ pol_r[i];
                else
                    pinReg_r[i] <= portLatch[i];
            end
        end
    end

    // ****************
    // auto-shutdown
    // ****************
    assign srcHit = shdnEn_r && |(shdnSrc & srcSel_r);
    assign shdnCond = shdnEn_r && (srcHit || eventBit_r || override_r);
    // hold keeps the pins parked until the next period boundary
    assign shdnNow = shdnCond || shdnHold_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            srcSel_r <= '0;
            shdnEn_r <= 1'b0;
            autoRestart_r <= 1'b0;
            override_r <= 1'b0;
        end
        else if (wrShdnSel)
        begin
            srcSel_r <= wrShdn[`SHDN_SRC_LO +: NSRC];
            shdnEn_r <= wrShdn[`SHDN_EN];
            autoRestart_r <= wrShdn[`SHDN_AUTO];
            override_r <= wrShdn[`SHDN_OVR];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            eventBit_r <= 1'b0;
        else if (srcHit)
            eventBit_r <= 1'b1;
        else if (wrShdnSel && wrShdn[`SHDN_EVENT])
            eventBit_r <= 1'b1;
        else if (wrShdnSel)
            eventBit_r <= 1'b0;
        else if (autoRestart_r && !override_r)
            eventBit_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            shdnHold_r <= 1'b0;
        else if (shdnCond)
            shdnHold_r <= 1'b1;
        else if (periodEvt)
            shdnHold_r <= 1'b0;
    end

    // shutdown bypasses the pin flops so a fault needs no clock edge
    always_comb
    begin
        for (int i = 0; i < CHANS; i++)
            pinOut[i] = (shdnNow && outEn_r[i] && steerEff[i]) ?
                        level_r[i] : pinReg_r[i];
    end

    // ****************
    // sync output
    // ****************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            syncOut <= 1'b0;
            syncPend_r <= 1'b0;
            syncCnt_r <= '0;
        end
        else
        begin
            syncOut <= 1'b0;
            if (periodEvt)
            begin
                // slaves follow this pulse; their period must not be shorter
                if (!syncRise_r || riseDly_r == '0)
                    syncOut <= 1'b1;
                else
                begin
                    syncPend_r <= 1'b1;
                    syncCnt_r <= TW'(1);
                end
            end
            else if (syncPend_r)
            begin
                if (syncCnt_r == riseDly_r)
                begin
                    syncOut <= 1'b1;
                    syncPend_r <= 1'b0;
                end
                else
                    syncCnt_r <= syncCnt_r + TW'(1);
            end
        end
    end
endmodule : pwm_output_shutdown_sync

// File: verif/out_stage_assertions.sv
// port-level checks of the pwm output stage
`timescale 1ns/1ps
module out_stage_checker #(
    parameter int TW = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic periodEvt,
    input wire logic [TW-1:0] riseTime,
    input wire logic [TW-1:0] fallTime,
    input wire logic syncOut
);
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pends");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] > 6'h05
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    timing_commit_a: assert property (
        $changed(fallTime) |-> $past(periodEvt))
        else $error("fall time changed off the period");
    sync_source_a: assert property (
        syncOut && riseTime != 0 |-> $past(periodEvt))
        else $error("sync not from period event");
    sync_seen_c: cover property ($rose(syncOut));
    commit_seen_c: cover property ($changed(fallTime));
    unmapped_seen_c: cover property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] > 6'h05);
endmodule : out_stage_checker

bind pwm_output_shutdown_sync out_stage_checker #(.TW(TW))
    out_stage_checker_i (
    .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periodEvt, .riseTime,
    .fallTime, .syncOut);

// File: verif/pwm_event_source.sv
// event generator and sync-following slave around the output stage
`timescale 1ns/1ps
module pwm_event_source #(
    parameter int PER = 16,
    parameter int RISE_AT = 2,
    parameter int FALL_AT = 8,
    parameter int SLAVE_PER = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic syncIn,
    output logic periodEvt,
    output logic riseEvt,
    output logic fallEvt,
    output logic [7:0] phase,
    output logic slaveEvt
);
    logic [7:0] slaveCnt;
    // silent while stopped, so pins hold their last state
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            phase <= 8'h00;
            periodEvt <= 1'b0;
            riseEvt <= 1'b0;
            fallEvt <= 1'b0;
        end
        else
        begin
            phase <= (phase == 8'(PER - 1)) ? 8'h00 : phase + 8'h01;
            periodEvt <= phase == 8'(PER - 1);
            riseEvt <= phase == 8'(RISE_AT - 1);
            fallEvt <= phase == 8'(FALL_AT - 1);
        end
    end
    // slave period kept longer so every sync restarts it
    always_ff @(posedge clk)
    begin
        if (rst || syncIn || slaveCnt == 8'(SLAVE_PER - 1))
            slaveCnt <= 8'h00;
        else
            slaveCnt <= slaveCnt + 8'h01;
    end
    assign slaveEvt = slaveCnt == 8'h00;
endmodule : pwm_event_source

// File: verif/pwm_output_shutdown_sync_bench.sv
// self-checking bench of the pwm output stage
`timescale 1ns/1ps
`include "pwm_out_regs.svh"
module pwm_output_shutdown_sync_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [5:0] modeChan = 6'h00;
    logic [5:0] portLatch = 6'h00;
    logic [7:0] shdnSrc = 8'h00;
    logic evRun = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, periodEvt, riseEvt, fallEvt, syncOut;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [15:0] riseTime, fallTime, rv, fv;
    logic [7:0] phase, sel;
    logic [5:0] pinOut, lat, mc, st, st2, pl, lv;
    int n_mismatch = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    pwm_output_shutdown_sync pwm_output_shutdown_sync_i (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .periodEvt, .riseEvt, .fallEvt,
        .modeChan, .portLatch, .shdnSrc, .pinOut, .riseTime, .fallTime,
        .syncOut);
    pwm_event_source pwm_event_source_i (.clk, .rst, .run(evRun),
        .syncIn(syncOut), .periodEvt, .riseEvt, .fallEvt, .phase,
        .slaveEvt());

    // ********************
    // helpers
    // ********************
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic axiWr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axiRd
    task automatic waitPh(input logic [7:0] p);
        do
            @(posedge clk);
        while (phase !== p);
    endtask : waitPh
    // stop the events mid-pulse so pins sit in the active state
    task automatic holdActive;
        waitPh(8'h0F);
        waitPh(8'h06);
        evRun <= 1'b0;
    endtask : holdActive
    function automatic logic [31:0] cfg(input logic [5:0] en, s, p, l);
        return {2'h0, l, 2'h0, p, 2'h0, s, 2'h0, en};
    endfunction : cfg
    function automatic logic [31:0] pinExp(input logic act,
                                           input logic [5:0] s, p);
        return 32'(s & (act ? ~p : p));
    endfunction : pinExp
    task end_sim;
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // ********************
    // scenarios
    // ********************
    initial
    begin
        void'($urandom(32'hE6E4CC5F));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        axiRd(`OFS_CTRL);
        chk("ctrl reset", d, `RST_CTRL);
        axiRd(`OFS_OUTCFG);
        chk("steer reset", 32'(d[13:8]), 32'(`RST_STEER));
        axiRd(8'h18);
        chk("unmapped read", 32'(r), 32'(`RESP_SLVERR));
        axiWr(8'h1C, 32'hFFFF_FFFF);
        chk("unmapped write", 32'(r), 32'(`RESP_SLVERR));
        for (int m = 0; m < 13; m++)
        begin
            {lat, mc, st, pl} = 24'($urandom());
            axiWr(`OFS_CTRL, (32'(m) << 1) | 32'h1);
            portLatch <= lat;
            modeChan <= mc;
            axiWr(`OFS_OUTCFG, cfg(m < 2 ? 6'h00 : 6'h3F, st, pl, 6'h00));
            repeat (2) @(posedge clk);
            #1;
            chk("pin source", 32'(pinOut), m < 2 ? 32'(lat & st)
                : 32'(mc ^ pl));
        end
        {st, st2, pl} = 18'($urandom());
        axiWr(`OFS_CTRL, 32'h1);
        evRun <= 1'b1;
        axiWr(`OFS_OUTCFG, cfg(6'h3F, st, pl, 6'h00));
        waitPh(8'h0F);
        waitPh(8'h06);
        #1 chk("active", 32'(pinOut), pinExp(1'b1, st, pl));
        waitPh(8'h0D);
        #1 chk("idle", 32'(pinOut), pinExp(1'b0, st, pl));
        holdActive();
        axiWr(`OFS_OUTCFG, cfg(6'h3F, st2, pl, 6'h00));
        repeat (2) @(posedge clk);
        #1 chk("steer now", 32'(pinOut), pinExp(1'b1, st2, pl));
        axiWr(`OFS_CTRL, 32'h21);
        axiWr(`OFS_OUTCFG, cfg(6'h3F, st, pl, 6'h00));
        repeat (2) @(posedge clk);
        #1 chk("steer held", 32'(pinOut), pinExp(1'b1, st2, pl));
        @(posedge clk);
        evRun <= 1'b1;
        waitPh(8'h0F);
        waitPh(8'h06);
        #1 chk("steer synced", 32'(pinOut), pinExp(1'b1, st, pl));
        {sel, lv} = 14'($urandom());
        sel = sel | 8'h01;
        axiWr(`OFS_OUTCFG, cfg(6'h3F, 6'h3F, pl, lv));
        axiWr(`OFS_SHDN, 32'h300 | 32'(sel));
        holdActive();
        shdnSrc <= ~sel;
        repeat (2) @(posedge clk);
        #1 chk("unselected", 32'(pinOut), pinExp(1'b1, 6'h3F, pl));
        @(posedge clk);
        shdnSrc <= sel & (~sel + 8'h01);
        #1 chk("instant shutdown", 32'(pinOut),
            32'(lv));
        @(posedge clk);
        shdnSrc <= 8'h00;
        repeat (3) @(posedge clk);
        #1 chk("wait period", 32'(pinOut), 32'(lv));
        @(posedge clk);
        evRun <= 1'b1;
        waitPh(8'h0F);
        waitPh(8'h06);
        #1 chk("auto restart", 32'(pinOut),
            pinExp(1'b1, 6'h3F, pl));
        axiWr(`OFS_SHDN, 32'hB00 | 32'(sel));
        waitPh(8'h0F);
        waitPh(8'h06);
        #1 chk("override", 32'(pinOut), 32'(lv));
        axiWr(`OFS_SHDN, 32'h500 | 32'(sel));
        repeat (2) @(posedge clk);
        #1 chk("sw shutdown", 32'(pinOut), 32'(lv));
        @(posedge clk);
        shdnSrc <= sel;
        axiWr(`OFS_SHDN, 32'h100 | 32'(sel));
        axiRd(`OFS_SHDN);
        chk("clear refused", 32'(d[10]), 32'h1);
        shdnSrc <= 8'h00;
        axiWr(`OFS_SHDN, 32'h100 | 32'(sel));
        axiRd(`OFS_SHDN);
        chk("clear taken", 32'(d[10]), 32'h0);
        {rv, fv} = $urandom();
        axiWr(`OFS_RISE, 32'(rv));
        axiWr(`OFS_FALL, 32'(fv));
        chk("rise buffered", 32'(riseTime), 32'h0);
        axiWr(`OFS_CTRL, 32'h41);
        waitPh(8'h0F);
        waitPh(8'h00);
        #1 chk("sync period", 32'(syncOut), 32'h1);
        waitPh(8'h03);
        chk("rise load", 32'(riseTime), 32'(rv));
        chk("fall load", 32'(fallTime), 32'(fv));
        axiRd(`OFS_CTRL);
        chk("load clear", 32'(d[6]), 32'h0);
        axiWr(`OFS_CTRL, 32'hC1);
        waitPh(8'h0F);
        waitPh(8'h03);
        #1 chk("rise at period", 32'(riseTime), 32'h0);
        end_sim();
    end

    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule : pwm_output_shutdown_sync_bench
